// File: hw/e1_event_cfg.svh
`ifndef E1_EVENT_CFG_SVH
`define E1_EVENT_CFG_SVH

// ---------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------
`define CLK_MHZ           100
`define LOS_AMP_TIME_US   1000
`define PERSIST_STEP_MS   100
`define PERSIST_MIN_STEPS 8'h01
`define PERSIST_MAX_STEPS 8'hFA

// ---------------------------------------------------------------
// frame layout and detection limits
// ---------------------------------------------------------------
`define FAS_WORD          7'h1B
`define MF_WORD           6'h0B
`define TS0_LAST_BIT      8'h07
`define BIT_A_POS         5
`define BIT_SA7_POS       1
`define BIT_NFAS_POS      6
`define BIT_SI_POS        7
`define FAS_LOSS_LIMIT    2'h3
`define ZERO_RUN_LIMIT    4'hA
`define AIS_WINDOW_LAST   9'h1FF
`define AIS_MIN_ZEROS     2'h3
`define MF_LAST_CHECK     4'hB
`define MF_AFTER_CHECK    4'hC
`define MF_EBIT_A         4'hD
`define MF_EBIT_B         4'hF

`endif

// File: hw/e1_event_pkg.sv
`default_nettype none
package e1_event_pkg;
  // frame alignment hunt and hold
  typedef enum logic [1:0] {
    AL_HUNT = 2'b00,
    AL_NFAS = 2'b01,
    AL_FAS2 = 2'b10,
    AL_SYNC = 2'b11
  } align_state_t;

  // one report per detected event, immediate, unqualified
  typedef struct packed {
    logic valid;
    logic signal_loss;
    logic remote_alarm;
    logic alarm_indication;
    logic far_crc_error;
  } event_report_t;
endpackage
`default_nettype wire

// File: hw/e1_layer1_event_detector.sv
// Function
// - remote alarm only when aligned and A=1
// - loss of signal after over 10 zeros
// - zero run and/or 1 ms low amplitude
// - alignment search keeps running during signal loss
// - AIS: unaligned, under 3 zeros per 512
// - each zero E-bit raises far CRC event
// - link ident: 2 of 3 Sa7 zero
// - every event reported to management at once
// - local persistence check yields operational status
// - timer preset in 100 ms steps, 0.1-25 s
// - timer within 50 ms or 10 percent
// - distinct activate and deactivate indications
`include "e1_event_cfg.svh"
`default_nettype none
module e1_layer1_event_detector
  import e1_event_pkg::*;
#(
  parameter int AMP_CYCLES  = `LOS_AMP_TIME_US * `CLK_MHZ,
  parameter int STEP_CYCLES = `PERSIST_STEP_MS * 1000 * `CLK_MHZ
) (
  input  wire logic          CLOCK_I,
  input  wire logic          RESETN_I,
  input  wire logic          LINE_CLK_I,
  input  wire logic          LINE_DATA_I,
  input  wire logic          LINE_MARK_I,
  input  wire logic          LOW_AMPL_I,
  input  wire logic          LOS_ZERO_EN_I,
  input  wire logic          LOS_AMPL_EN_I,
  input  wire logic          LOCAL_QUAL_I,
  input  wire logic [7:0]    PERSIST_STEPS_I,
  output logic               ALIGNED_O,
  output logic               SIGNAL_LOSS_EVT_O,
  output logic               REMOTE_ALARM_EVT_O,
  output logic               ALARM_INDICATION_EVT_O,
  output logic               FAR_CRC_ERROR_EVT_O,
  output logic               LINK_IDENT_SEEN_IND_O,
  output event_report_t      EVENT_LOG_REPORT_O,
  output logic               LINK_ACTIVE_IND_O,
  output logic               LINK_INACTIVE_IND_O
);
  localparam logic [23:0] AMP_N  = 24'(AMP_CYCLES - 1);
  localparam logic [23:0] STEP_N = 24'(STEP_CYCLES - 1);

  // ---------------------------------------------------------------
  // pin sampling
  // ---------------------------------------------------------------
  // line clock and data are async: two flops each, edge found after
  logic [3:0] s1_r, s2_r;
  logic       lclk_d_r;
  logic       bit_evt, bit_d, bit_m, low_a;
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      s1_r     <= 4'h0;
      s2_r     <= 4'h0;
      lclk_d_r <= 1'b0;
    end else begin
      s1_r     <= {LOW_AMPL_I, LINE_MARK_I, LINE_DATA_I, LINE_CLK_I};
      s2_r     <= s1_r;
      lclk_d_r <= s2_r[0];
    end
  end
  assign bit_evt = s2_r[0] & ~lclk_d_r;
  assign bit_d   = s2_r[1];
  assign bit_m   = s2_r[2];
  assign low_a   = s2_r[3];

  // ---------------------------------------------------------------
  // frame and multiframe alignment
  // ---------------------------------------------------------------
  align_state_t st_r, st_nxt;
  logic [7:0] sr_r, sr_nxt, pos_r, pos_nxt, pos;
  logic       fas_fr_r, fas_fr_nxt, ts0_end;
  logic [1:0] ferr_r, ferr_nxt;
  logic [5:0] mfsr_r, mfsr_nxt;
  logic [3:0] mf_r, mf_nxt;
  logic       mfok_r, mfok_nxt, rai_r, rai_nxt, crc_nxt;
  logic [2:0] sa7_r, sa7_nxt;
  // the hunt never looks at loss of signal, so it never stalls
  always_comb begin
    pos        = pos_r + 8'h01;
    sr_nxt     = sr_r;
    pos_nxt    = pos_r;
    st_nxt     = st_r;
    fas_fr_nxt = fas_fr_r;
    ferr_nxt   = ferr_r;
    mfsr_nxt   = mfsr_r;
    mf_nxt     = mf_r;
    mfok_nxt   = mfok_r;
    rai_nxt    = rai_r;
    sa7_nxt    = sa7_r;
    crc_nxt    = 1'b0;
    ts0_end    = 1'b0;
    if (bit_evt) begin
      sr_nxt  = {sr_r[6:0], bit_d};
      pos_nxt = pos;
      ts0_end = (pos == `TS0_LAST_BIT);
      case (st_r)
        AL_HUNT: begin
          if (sr_nxt[6:0] == `FAS_WORD) begin
            pos_nxt    = `TS0_LAST_BIT;
            fas_fr_nxt = 1'b0;
            st_nxt     = AL_NFAS;
          end
        end
        default: begin
          if (ts0_end) begin
            fas_fr_nxt = ~fas_fr_r;
            if (fas_fr_r) begin
              // three bad words in a row drop sync
              if (sr_nxt[6:0] == `FAS_WORD) begin
                ferr_nxt = 2'h0;
                if (st_r == AL_FAS2) st_nxt = AL_SYNC;
              end else if (st_r != AL_SYNC || ferr_r + 2'h1 == `FAS_LOSS_LIMIT) begin
                st_nxt = AL_HUNT;
              end else begin
                ferr_nxt = ferr_r + 2'h1;
              end
            end else if (st_r == AL_NFAS) begin
              st_nxt = sr_nxt[`BIT_NFAS_POS] ? AL_FAS2 : AL_HUNT;
            end else if (st_r == AL_SYNC) begin
              rai_nxt  = sr_nxt[`BIT_A_POS];
              sa7_nxt  = {sa7_r[1:0], sr_nxt[`BIT_SA7_POS]};
              mfsr_nxt = {mfsr_r[4:0], sr_nxt[`BIT_SI_POS]};
              if (mfok_r && (mf_r == `MF_EBIT_A || mf_r == `MF_EBIT_B))
                crc_nxt = ~sr_nxt[`BIT_SI_POS];
              if (mfok_r && mf_r == `MF_LAST_CHECK && mfsr_nxt != `MF_WORD)
                mfok_nxt = 1'b0;
              else if (!mfok_r && mfsr_nxt == `MF_WORD) begin
                mfok_nxt = 1'b1;
                mf_nxt   = `MF_AFTER_CHECK;
              end
            end
            if (!(st_r == AL_SYNC && !fas_fr_r && !mfok_r && mfsr_nxt == `MF_WORD))
              mf_nxt = mf_r + 4'h1;
          end
        end
      endcase
    end
    if (st_nxt != AL_SYNC) begin
      ferr_nxt = 2'h0;
      mfok_nxt = 1'b0;
      rai_nxt  = 1'b0;
      sa7_nxt  = 3'h7;
    end
  end
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      st_r <= AL_HUNT;
      sr_r <= 8'h00;
      pos_r <= 8'h00;
      fas_fr_r <= 1'b0;
      ferr_r <= 2'h0;
      mfsr_r <= 6'h00;
      mf_r <= 4'h0;
      mfok_r <= 1'b0;
      rai_r <= 1'b0;
      sa7_r <= 3'h7;
    end else begin
      st_r <= st_nxt;
      sr_r <= sr_nxt;
      pos_r <= pos_nxt;
      fas_fr_r <= fas_fr_nxt;
      ferr_r <= ferr_nxt;
      mfsr_r <= mfsr_nxt;
      mf_r <= mf_nxt;
      mfok_r <= mfok_nxt;
      rai_r <= rai_nxt;
      sa7_r <= sa7_nxt;
    end
  end

  // ---------------------------------------------------------------
  // loss of signal and AIS
  // ---------------------------------------------------------------
  logic [3:0]  zrun_r, zrun_nxt;
  logic [23:0] amp_r, amp_nxt;
  logic [8:0]  win_r, win_nxt;
  logic [1:0]  zc_r, zc_nxt;
  logic        los_r, los_nxt, ais_r, ais_nxt;
  // both methods selectable; either one alone is enough
  always_comb begin
    zrun_nxt = zrun_r;
    win_nxt  = win_r;
    zc_nxt   = zc_r;
    ais_nxt  = ais_r;
    amp_nxt  = (low_a && amp_r != AMP_N) ? amp_r + 24'h1 : (low_a ? amp_r : 24'h0);
    if (bit_evt) begin
      zrun_nxt = bit_m ? 4'h0 : (zrun_r == 4'hF ? zrun_r : zrun_r + 4'h1);
      win_nxt  = win_r + 9'h1;
      if (!bit_d && zc_r != `AIS_MIN_ZEROS) zc_nxt = zc_r + 2'h1;
      if (win_r == `AIS_WINDOW_LAST) begin
        ais_nxt = (st_r != AL_SYNC) && (zc_nxt < `AIS_MIN_ZEROS);
        zc_nxt  = 2'h0;
      end
    end
    if (st_r == AL_SYNC) ais_nxt = 1'b0;
    los_nxt = (LOS_ZERO_EN_I && zrun_r > `ZERO_RUN_LIMIT) ||
              (LOS_AMPL_EN_I && amp_r == AMP_N);
  end
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      zrun_r <= 4'h0;
      amp_r  <= 24'h0;
      win_r  <= 9'h0;
      zc_r   <= 2'h0;
      los_r  <= 1'b0;
      ais_r  <= 1'b0;
    end else begin
      zrun_r <= zrun_nxt;
      amp_r  <= amp_nxt;
      win_r  <= win_nxt;
      zc_r   <= zc_nxt;
      los_r  <= los_nxt;
      ais_r  <= ais_nxt;
    end
  end

  // ---------------------------------------------------------------
  // event reports
  // ---------------------------------------------------------------
  event_report_t rep_nxt;
  logic          ident_nxt;
  // rising edges are reported at once, no qualification
  always_comb begin
    rep_nxt.signal_loss      = los_nxt & ~los_r;
    rep_nxt.remote_alarm     = rai_nxt & ~rai_r;
    rep_nxt.alarm_indication = ais_nxt & ~ais_r;
    rep_nxt.far_crc_error    = crc_nxt;
    rep_nxt.valid            = rep_nxt.signal_loss | rep_nxt.remote_alarm |
                               rep_nxt.alarm_indication | rep_nxt.far_crc_error;
    ident_nxt = (st_nxt == AL_SYNC) &&
                (sa7_nxt == 3'h0 || sa7_nxt == 3'h1 || sa7_nxt == 3'h2 || sa7_nxt == 3'h4);
  end
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      EVENT_LOG_REPORT_O    <= '0;
      LINK_IDENT_SEEN_IND_O <= 1'b0;
    end else begin
      EVENT_LOG_REPORT_O    <= rep_nxt;
      LINK_IDENT_SEEN_IND_O <= ident_nxt;
    end
  end
  assign ALIGNED_O              = (st_r == AL_SYNC);
  assign SIGNAL_LOSS_EVT_O      = EVENT_LOG_REPORT_O.signal_loss;
  assign REMOTE_ALARM_EVT_O     = EVENT_LOG_REPORT_O.remote_alarm;
  assign ALARM_INDICATION_EVT_O = EVENT_LOG_REPORT_O.alarm_indication;
  assign FAR_CRC_ERROR_EVT_O    = EVENT_LOG_REPORT_O.far_crc_error;

  // ---------------------------------------------------------------
  // persistence check
  // ---------------------------------------------------------------
  logic [23:0] pre_r, pre_nxt;
  logic [7:0]  stp_r, stp_nxt, lim;
  logic        op_r, op_nxt, act_nxt, dea_nxt, want_op;
  // prescaler restarts with the timer, so error stays under one cycle
  always_comb begin
    lim = (PERSIST_STEPS_I < `PERSIST_MIN_STEPS) ? `PERSIST_MIN_STEPS :
          (PERSIST_STEPS_I > `PERSIST_MAX_STEPS) ? `PERSIST_MAX_STEPS : PERSIST_STEPS_I;
    want_op = (st_r == AL_SYNC) && !los_r && !ais_r && !rai_r;
    pre_nxt = 24'h0;
    stp_nxt = 8'h00;
    op_nxt  = op_r;
    act_nxt = 1'b0;
    dea_nxt = 1'b0;
    if (LOCAL_QUAL_I && want_op != op_r) begin
      pre_nxt = (pre_r == STEP_N) ? 24'h0 : pre_r + 24'h1;
      stp_nxt = (pre_r == STEP_N) ? stp_r + 8'h01 : stp_r;
      if (pre_r == STEP_N && stp_r + 8'h01 == lim) begin
        op_nxt  = want_op;
        act_nxt = want_op;
        dea_nxt = ~want_op;
        stp_nxt = 8'h00;
      end
    end
  end
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      pre_r <= 24'h0;
      stp_r <= 8'h00;
      op_r  <= 1'b0;
      LINK_ACTIVE_IND_O   <= 1'b0;
      LINK_INACTIVE_IND_O <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      stp_r <= stp_nxt;
      op_r  <= op_nxt;
      LINK_ACTIVE_IND_O   <= act_nxt;
      LINK_INACTIVE_IND_O <= dea_nxt;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);
  AST_RAI_ALIGNED: assert property (rai_r |-> st_r == AL_SYNC)
    else $error("remote alarm while unaligned");
  AST_ZERO_RUN: assert property (LOS_ZERO_EN_I && zrun_r > `ZERO_RUN_LIMIT |=> los_r)
    else $error("zero run did not raise signal loss");
  AST_AMPL: assert property (!los_r && !LOS_ZERO_EN_I |-> ##1 (!$rose(los_r) || $past(amp_r) == AMP_N))
    else $error("amplitude loss too early");
  AST_HUNT_GOES: assert property (st_r == AL_HUNT && bit_evt && sr_nxt[6:0] == `FAS_WORD |=> st_r == AL_NFAS)
    else $error("alignment hunt stalled");
  AST_AIS_UNALIGNED: assert property (ais_r |-> st_r != AL_SYNC)
    else $error("AIS while aligned");
  AST_CRC_CAUSE: assert property (FAR_CRC_ERROR_EVT_O |-> $past(mfok_r) && $past(sr_nxt[`BIT_SI_POS]) == 1'b0)
    else $error("far CRC event without zero E-bit");
  AST_IDENT: assert property (LINK_IDENT_SEEN_IND_O |-> $past(st_nxt) == AL_SYNC)
    else $error("ident seen while unaligned");
  AST_LOG: assert property ($rose(los_r) |-> SIGNAL_LOSS_EVT_O && EVENT_LOG_REPORT_O.valid)
    else $error("signal loss not reported");
  AST_ACTIVATE: assert property ($rose(op_r) |-> LINK_ACTIVE_IND_O && !LINK_INACTIVE_IND_O)
    else $error("activate indication missing");
  AST_DEACTIVATE: assert property ($fell(op_r) |-> LINK_INACTIVE_IND_O ##1 !LINK_INACTIVE_IND_O)
    else $error("deactivate indication wrong");
  AST_HOLD: assert property (!LOCAL_QUAL_I |=> $stable(op_r))
    else $error("status moved without local check");
  COV_SYNC: cover property (st_r == AL_NFAS ##[1:1000] st_r == AL_SYNC);
  COV_LOS: cover property ($rose(los_r));
  COV_ACT: cover property (LINK_ACTIVE_IND_O);
  COV_CRC: cover property (FAR_CRC_ERROR_EVT_O);
endmodule
`default_nettype wire

// File: verif/e1_line_source.sv
`include "e1_event_cfg.svh"
`default_nettype none
// ---------------------------------------------------------------
// far-end line transmitter: framed, all-ones or silent line
// ---------------------------------------------------------------
module e1_line_source (
  input  wire logic [1:0] mode_i,
  input  wire logic       a_bit_i,
  input  wire logic       sa7_bit_i,
  output logic            line_clk_o,
  output logic            line_data_o,
  output logic            line_mark_o
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [6:0] ALIGN_WORD = `FAS_WORD;
  int unsigned           bit_cnt;

  // bit of a two-frame cycle; no crc multiframe, so si stays one
  function automatic logic frame_bit(input int unsigned n);
    int unsigned b   = n % 256;
    logic        odd = n[8];
    if (b == 0) return 1'b1;
    if (b > 7) return b[0];           // alternating payload never holds long zero runs
    if (!odd) return ALIGN_WORD[7 - b];
    if (b == 2) return a_bit_i;
    if (b == 6) return sa7_bit_i;
    return 1'b1;
  endfunction

  // line clock runs free; data moves on the falling edge, stable at rise
  initial begin
    line_clk_o  = 1'b0;
    line_data_o = 1'b1;
    line_mark_o = 1'b1;
    bit_cnt     = 0;
    forever begin
      #62.5 line_clk_o = 1'b1;
      #62.5 line_clk_o = 1'b0;
      bit_cnt = (bit_cnt + 1) % 512;
      case (mode_i)
        2'h1:    line_data_o = 1'b1;
        2'h2:    line_data_o = 1'b0;
        default: line_data_o = frame_bit(bit_cnt);
      endcase
      line_mark_o = line_data_o;      // a zero is sent as no pulse
    end
  end
endmodule
`default_nettype wire

// File: verif/tb_e1_layer1_event_detector.sv
`default_nettype none
// ---------------------------------------------------------------
// bench: far-end line model, scenarios, verdict
// ---------------------------------------------------------------
module tb_e1_layer1_event_detector import e1_event_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int AMP  = 20;
  localparam int STEP = 50;
  logic          clock, resetn, line_clk, line_data, line_mark, low_ampl;
  logic          los_zero_en, los_ampl_en, local_qual, a_bit, sa7_bit;
  logic [1:0]    mode;
  logic [7:0]    steps;
  logic          aligned, los_evt, rai_evt, ais_evt, crc_evt, ident, act, inact;
  event_report_t rpt;
  int            n_errors, checks_done, n;

  e1_layer1_event_detector #(.AMP_CYCLES(AMP), .STEP_CYCLES(STEP)) dut (
    .CLOCK_I(clock), .RESETN_I(resetn), .LINE_CLK_I(line_clk), .LINE_DATA_I(line_data),
    .LINE_MARK_I(line_mark), .LOW_AMPL_I(low_ampl), .LOS_ZERO_EN_I(los_zero_en),
    .LOS_AMPL_EN_I(los_ampl_en), .LOCAL_QUAL_I(local_qual), .PERSIST_STEPS_I(steps),
    .ALIGNED_O(aligned), .SIGNAL_LOSS_EVT_O(los_evt), .REMOTE_ALARM_EVT_O(rai_evt),
    .ALARM_INDICATION_EVT_O(ais_evt), .FAR_CRC_ERROR_EVT_O(crc_evt),
    .LINK_IDENT_SEEN_IND_O(ident), .EVENT_LOG_REPORT_O(rpt),
    .LINK_ACTIVE_IND_O(act), .LINK_INACTIVE_IND_O(inact));

  e1_line_source src (.mode_i(mode), .a_bit_i(a_bit), .sa7_bit_i(sa7_bit),
    .line_clk_o(line_clk), .line_data_o(line_data), .line_mark_o(line_mark));

  // 100 MHz system clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // counts and verdict
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask

  task automatic chk_range(input int got, input int lo, input int hi, input string what);
    checks_done++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("ERROR %0t %s: %0d cycles", $time, what, got);
    end
  endtask

  // 0 aligned, 1 loss, 2 remote alarm, 3 ais, 4 ident, 5 active, 6 inactive
  function automatic logic pick(input int sel);
    case (sel)
      0:       return aligned;
      1:       return los_evt;
      2:       return rai_evt;
      3:       return ais_evt;
      4:       return ident;
      5:       return act;
      default: return inact;
    endcase
  endfunction

  // bounded wait; n is cycles until the signal shows high
  task automatic wait_for(input int sel, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge clock);
      #1;
      cnt++;
    end while (pick(sel) !== 1'b1 && cnt < lim);
    chk_bit(pick(sel), 1'b1, "wait timed out");
    if (pick(sel) !== 1'b1) report_and_stop();
  endtask

  // signal must stay low for len cycles
  task automatic quiet(input int sel, input int len);
    repeat (len) begin
      @(posedge clock);
      #1;
      chk_bit(pick(sel), 1'b0, "unexpected indication");
    end
  endtask

  // preset 0 acts as one step, so the timer is STEP cycles
  task automatic align_and_activate();
    wait_for(0, 20000, n);
    wait_for(5, 200, n);
    chk_range(n, STEP - 2, STEP + 10, "activate delay");
  endtask

  task automatic ident_test();
    @(posedge clock);
    sa7_bit <= 1'b0;
    wait_for(4, 20000, n);
    chk_bit(aligned, 1'b1, "aligned during ident");
    @(posedge clock);
    sa7_bit <= 1'b1;
  endtask

  task automatic rai_test();
    @(posedge clock);
    a_bit <= 1'b1;
    wait_for(2, 20000, n);
    chk_bit(rpt.valid & rpt.remote_alarm, 1'b1, "report lacks remote alarm");
    wait_for(6, 200, n);
    chk_range(n, STEP - 2, STEP + 10, "deactivate delay");
    @(posedge clock);
    a_bit <= 1'b0;
    wait_for(5, 20000, n);
  endtask

  // switch just after a line rise carrying a mark, so the run starts from zero
  task automatic los_zero_test();
    repeat (64) begin
      @(posedge line_clk);
      if (line_data === 1'b1) break;
    end
    chk_bit(line_data, 1'b1, "no mark bit before zero run");
    @(posedge clock);
    mode <= 2'h2;
    wait_for(1, 400, n);
    chk_range(n, 136, 146, "eleventh zero");
    chk_bit(rpt.signal_loss, 1'b1, "report lacks signal loss");
    wait_for(6, 200, n);
    chk_range(n, STEP - 2, STEP + 10, "deactivate after loss");
  endtask

  task automatic ais_test();
    @(posedge clock);
    mode <= 2'h1;
    wait_for(3, 40000, n);
    chk_bit(aligned, 1'b0, "ais while aligned");
    chk_bit(rpt.alarm_indication, 1'b1, "report lacks ais");
  endtask

  // alignment must recover while low amplitude holds signal loss
  task automatic ampl_test();
    @(posedge clock);
    mode        <= 2'h0;
    los_zero_en <= 1'b0;                 // amplitude method alone drives the loss
    los_ampl_en <= 1'b1;
    low_ampl    <= 1'b1;
    wait_for(1, 100, n);
    chk_range(n, AMP, AMP + 8, "amplitude hold");
    wait_for(0, 20000, n);
    quiet(5, 300);
    @(posedge clock);
    local_qual <= 1'b0;
    low_ampl   <= 1'b0;
    quiet(5, 300);
    @(posedge clock);
    local_qual <= 1'b1;
    wait_for(5, 200, n);
    chk_range(n, STEP - 2, STEP + 10, "activate after release");
  endtask

  // main sequence
  initial begin
    n_errors    = 0;
    checks_done = 0;
    resetn      = 1'b0;
    low_ampl    = 1'b0;
    los_zero_en = 1'b1;
    los_ampl_en = 1'b0;
    local_qual  = 1'b1;
    steps       = 8'h00;
    mode        = 2'h0;
    a_bit       = 1'b0;
    sa7_bit     = 1'b1;
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    #1;
    chk_bit(act | inact | aligned | rpt.valid | crc_evt | los_evt | ident, 1'b0, "outputs after reset");
    align_and_activate();
    ident_test();
    rai_test();
    los_zero_test();
    ais_test();
    ampl_test();
    report_and_stop();
  end
endmodule
`default_nettype wire
